// ==== dv/bridge_cfg_tail_tb.sv ====
// Purpose: Self-checking bench for the bridge header tail
// Assumes: Downstream and upstream instances share all inputs
// Notes:   Upstream instance drives three port resets
`timescale 1ns/10ps
`default_nettype none
module bridge_cfg_tail_tb;
   import bridge_cfg_pkg::*;
   // ==========================================================
   // Signals
   logic        sys_clk_i, srst_i, cfg_rd_i, cfg_wr_i, load_wr_i, cfg_ack_o, up_ack;
   logic [7:0]  cfg_addr_i, load_addr_i;
   logic [3:0]  cfg_be_i, load_be_i;
   logic [31:0] cfg_wdata_i, load_wdata_i, cfg_rdata_o, up_rdata, io_addr_i, mem_addr_i;
   logic        poison_seen_i, poison_report_o, io_in_window_i, hot_reset_o;
   logic        io_fwd_up_o, io_fwd_down_o, vga_io_hit_o, vga_mem_hit_o;
   logic [2:0]  err_msg_i, err_fwd_o, up_rst_n;
   logic [15:0] io_top_upper_o;
   logic [0:0]  port_rst_n_o;
   logic [63:0] rq;          // Read data, upstream in the top half
   int          num_errors;
   int          compares;
   // ==========================================================
   // Instances
   bridge_cfg_tail #(.IS_UPSTREAM(1'b0), .NUM_RST(1)) u_bridge_cfg_tail (
      .sys_clk_i, .srst_i, .cfg_rd_i, .cfg_wr_i, .cfg_addr_i, .cfg_be_i, .cfg_wdata_i,
      .cfg_rdata_o, .cfg_ack_o, .load_wr_i, .load_addr_i, .load_be_i, .load_wdata_i,
      .poison_seen_i, .err_msg_i, .poison_report_o, .err_fwd_o, .io_addr_i,
      .io_in_window_i, .mem_addr_i, .io_fwd_up_o, .io_fwd_down_o, .vga_io_hit_o,
      .vga_mem_hit_o, .io_top_upper_o, .hot_reset_o, .port_rst_n_o);
   bridge_cfg_tail #(.IS_UPSTREAM(1'b1), .NUM_RST(3)) u_bridge_cfg_tail_up (
      .sys_clk_i, .srst_i, .cfg_rd_i, .cfg_wr_i, .cfg_addr_i, .cfg_be_i, .cfg_wdata_i,
      .cfg_rdata_o(up_rdata), .cfg_ack_o(up_ack), .load_wr_i, .load_addr_i, .load_be_i,
      .load_wdata_i, .poison_seen_i, .err_msg_i, .poison_report_o(), .err_fwd_o(),
      .io_addr_i, .io_in_window_i, .mem_addr_i, .io_fwd_up_o(), .io_fwd_down_o(),
      .vga_io_hit_o(), .vga_mem_hit_o(), .io_top_upper_o(), .hot_reset_o(),
      .port_rst_n_o(up_rst_n));
   cfg_host u_cfg_host (
      .sys_clk_i, .rdata_pair_i({up_rdata, cfg_rdata_o}), .cfg_ack_i(cfg_ack_o & up_ack),
      .cfg_rd_o(cfg_rd_i), .cfg_wr_o(cfg_wr_i), .cfg_addr_o(cfg_addr_i),
      .cfg_be_o(cfg_be_i), .cfg_wdata_o(cfg_wdata_i), .load_wr_o(load_wr_i),
      .load_addr_o(load_addr_i), .load_be_o(load_be_i), .load_wdata_o(load_wdata_i));
   // 100 MHz clock
   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   // ==========================================================
   // Shared tasks
   function automatic logic [31:0] pm_exp(input logic [7:0] nxt);
      return {WAKE_SUP_RST, 2'b11, AUX_CUR_RST, 3'b000, PM_REV, nxt, PM_CAP_ID};
   endfunction
   task automatic end_sim();
      $display("Errors %0d, compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         $display("[FAIL] %0t exp %h got %h", $time, exp, got);
         num_errors++;
      end
   endtask
   // Config access; a missing ack ends the run
   task automatic acc(input logic wr, input logic [7:0] a, input logic [3:0] be,
                      input logic [31:0] d);
      logic ok;
      u_cfg_host.xfer(wr, a, be, d, rq, ok);
      if (ok !== 1'b1) begin
         $display("[FAIL] %0t exp %h got %h", $time, 1'b1, ok);
         num_errors++;
         end_sim();
      end
   endtask
   // Event pulse, gated result one cycle later as {report, fwd}
   task automatic ev(input logic p, input logic [2:0] e, input logic [3:0] x);
      @(posedge sys_clk_i);
      {poison_seen_i, err_msg_i} <= {p, e};
      @(posedge sys_clk_i);
      {poison_seen_i, err_msg_i} <= 4'h0;
      #1;
      chk(32'(x), 32'({poison_report_o, err_fwd_o}));
   endtask
   // Decode inputs, result {up, down, vga io, vga mem} one cycle later
   task automatic dec(input logic [31:0] io, input logic w, input logic [31:0] m,
                      input logic [3:0] x);
      @(posedge sys_clk_i);
      {io_addr_i, io_in_window_i, mem_addr_i} <= {io, w, m};
      @(posedge sys_clk_i);
      #1;
      chk(32'(x), 32'({io_fwd_up_o, io_fwd_down_o, vga_io_hit_o, vga_mem_hit_o}));
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_defaults();
      acc(1'b0, OFS_IO_TOP, 4'hf, 32'h0);
      chk(32'h0, rq[31:0]);
      acc(1'b0, OFS_CAP_HEAD, 4'hf, 32'h0);
      chk({24'h0, CAP_HEAD_VAL}, rq[31:0]);
      acc(1'b0, OFS_IRQ_BRG, 4'hf, 32'h0);
      chk(32'h0, rq[31:0]);
      acc(1'b0, OFS_PM_CAP, 4'hf, 32'h0);
      chk(pm_exp(PM_NEXT_DN), rq[31:0]);
      chk(pm_exp(PM_NEXT_UP), rq[63:32]);
      chk(32'h7, 32'(up_rst_n));
      chk(32'h0, 32'(hot_reset_o));
   endtask
   task automatic t_regs();
      acc(1'b1, OFS_IO_TOP, 4'hc, 32'habcd_0000);
      chk(32'habcd, 32'(io_top_upper_o));
      acc(1'b1, OFS_IO_TOP, 4'h5, 32'hff12_ffff);
      acc(1'b0, OFS_IO_TOP, 4'hf, 32'h0);
      chk(32'hab12_0000, rq[31:0]);
      acc(1'b1, OFS_IRQ_BRG, 4'hb, 32'hffff_ffff);
      acc(1'b1, OFS_IRQ_BRG, 4'h4, 32'hffbf_ffff);
      acc(1'b0, OFS_IRQ_BRG, 4'hf, 32'h0);
      chk(32'h001f_00ff, rq[31:0]);
      acc(1'b1, OFS_CAP_HEAD, 4'hf, 32'hffff_ffff);
      acc(1'b1, OFS_PM_CAP, 4'hf, 32'h0);
      acc(1'b1, 8'h38, 4'hf, 32'hffff_ffff);
      acc(1'b0, 8'h38, 4'hf, 32'h0);
      chk(32'h0, rq[31:0]);
      acc(1'b0, OFS_CAP_HEAD, 4'hf, 32'h0);
      chk(32'h40, rq[31:0]);
      acc(1'b0, OFS_PM_CAP, 4'hf, 32'h0);
      chk(pm_exp(PM_NEXT_DN), rq[31:0]);
      acc(1'b1, OFS_IRQ_BRG, 4'hf, 32'h0);
   endtask
   task automatic t_events();
      ev(1'b1, 3'h7, 4'h0);
      acc(1'b1, OFS_IRQ_BRG, 4'h4, 32'h0003_0000);
      ev(1'b1, 3'h5, 4'hd);
      ev(1'b0, 3'h2, 4'h2);
   endtask
   task automatic t_decode();
      acc(1'b1, OFS_IRQ_BRG, 4'h4, 32'h0004_0000);
      dec(32'h0000_0100, 1'b1, 32'h000a_0000, 4'h8);
      dec(32'h0000_0010, 1'b1, 32'h0, 4'h4);
      dec(32'h0001_0100, 1'b1, 32'h0, 4'h4);
      dec(32'h0000_0100, 1'b0, 32'h0, 4'h0);
      acc(1'b1, OFS_IRQ_BRG, 4'h4, 32'h0008_0000);
      dec(32'h0000_13b0, 1'b1, 32'h000a_0000, 4'h7);
      dec(32'h0000_03bc, 1'b0, 32'h000b_ffff, 4'h1);
      dec(32'h0000_07df, 1'b0, 32'h000c_0000, 4'h2);
      dec(32'h0000_03bb, 1'b0, 32'h0009_ffff, 4'h2);
      dec(32'h0000_03e0, 1'b0, 32'h0, 4'h0);
      dec(32'h0001_03c0, 1'b0, 32'h0, 4'h0);
      acc(1'b1, OFS_IRQ_BRG, 4'h4, 32'h0018_0000);
      dec(32'h0000_13b0, 1'b0, 32'h0, 4'h0);
      dec(32'h0000_03c0, 1'b0, 32'h0, 4'h2);
      acc(1'b1, OFS_IRQ_BRG, 4'h4, 32'h0);
   endtask
   task automatic t_sbr();
      acc(1'b1, OFS_IRQ_BRG, 4'h4, 32'h0040_0000);
      @(posedge sys_clk_i);
      #1;
      chk(32'h1, 32'(hot_reset_o));
      chk(32'h0, 32'(port_rst_n_o));
      chk(32'h0, 32'(up_rst_n));
      acc(1'b1, OFS_IRQ_BRG, 4'h4, 32'h0);
      @(posedge sys_clk_i);
      #1;
      chk(32'h7, 32'(up_rst_n));
      chk(32'h1, 32'(port_rst_n_o));
   endtask
   task automatic t_loader();
      u_cfg_host.load(OFS_PM_CAP, 4'hf, 32'h0);
      acc(1'b0, OFS_PM_CAP, 4'hf, 32'h0);
      chk(pm_exp(PM_NEXT_DN) & 32'h001f_ffff, rq[31:0]);
      u_cfg_host.load(OFS_PM_CAP, 4'hf, 32'hffff_ffff);
      u_cfg_host.load(OFS_IRQ_BRG, 4'h2, 32'h0000_0100);
      acc(1'b0, OFS_PM_CAP, 4'hf, 32'h0);
      chk(pm_exp(PM_NEXT_DN) | 32'hffe0_0000, rq[31:0]);
      chk(pm_exp(PM_NEXT_UP) | 32'hffe0_0000, rq[63:32]);
      acc(1'b0, OFS_IRQ_BRG, 4'hf, 32'h0);
      chk(32'h0000_0100, rq[31:0]);
      chk(32'h0, rq[63:32]);
   endtask
   // ==========================================================
   // Main sequence, with a second reset in mid-run
   initial begin
      num_errors = 0;
      compares = 0;
      srst_i = 1'b1;
      {poison_seen_i, err_msg_i, io_addr_i, io_in_window_i, mem_addr_i} = '0;
      repeat (3) @(posedge sys_clk_i);
      srst_i <= 1'b0;
      t_defaults();
      t_regs();
      t_events();
      t_decode();
      t_sbr();
      t_loader();
      @(posedge sys_clk_i);
      srst_i <= 1'b1;
      @(posedge sys_clk_i);
      srst_i <= 1'b0;
      t_defaults();
      end_sim();
   end
endmodule // bridge_cfg_tail_tb
`default_nettype wire

// ==== dv/cfg_host.sv ====
// Purpose: Host model issuing config requests and loader writes
// Assumes: One request per call, strobes one cycle wide
// Notes:   Released address and data lines carry the inverse value
`timescale 1ns/10ps
`default_nettype none
module cfg_host (
   // Clock
   input  wire logic        sys_clk_i,
   // Answers from both ports
   input  wire logic [63:0] rdata_pair_i,
   input  wire logic        cfg_ack_i,
   // Config requests
   output logic             cfg_rd_o,
   output logic             cfg_wr_o,
   output logic [7:0]       cfg_addr_o,
   output logic [3:0]       cfg_be_o,
   output logic [31:0]      cfg_wdata_o,
   // Loader writes
   output logic             load_wr_o,
   output logic [7:0]       load_addr_o,
   output logic [3:0]       load_be_o,
   output logic [31:0]      load_wdata_o
);
   // ==========================================================
   // Idle bus at time zero
   initial begin
      {cfg_rd_o, cfg_wr_o, cfg_addr_o, cfg_be_o, cfg_wdata_o} = '0;
      {load_wr_o, load_addr_o, load_be_o, load_wdata_o} = '0;
   end
   // One config cycle, answer sampled at the ack edge
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [3:0] be,
                       input logic [31:0] d, output logic [63:0] q, output logic ok);
      ok = 1'b0;
      q = '0;
      @(posedge sys_clk_i);
      {cfg_rd_o, cfg_wr_o, cfg_addr_o, cfg_be_o, cfg_wdata_o} <= {~wr, wr, a, be, d};
      @(posedge sys_clk_i);
      {cfg_rd_o, cfg_wr_o, cfg_addr_o, cfg_wdata_o} <= {2'b00, ~a, ~d};
      for (int n = 0; n < 4 && !ok; n++) begin
         @(posedge sys_clk_i);
         if (cfg_ack_i === 1'b1) begin
            q = rdata_pair_i;
            ok = 1'b1;
         end
      end
   endtask
   // Loader write of read-only defaults
   task automatic load(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      @(posedge sys_clk_i);
      {load_wr_o, load_addr_o, load_be_o, load_wdata_o} <= {1'b1, a, be, d};
      @(posedge sys_clk_i);
      {load_wr_o, load_addr_o, load_wdata_o} <= {1'b0, ~a, ~d};
   endtask
endmodule // cfg_host
`default_nettype wire

// ==== hw/bridge_cfg_pkg.sv ====
// Purpose: Constants for the bridge configuration header tail
// Assumes: Byte addresses of dword-aligned configuration registers
// Notes:   Reset values and field positions live here, except the bridge control and D1/D2/DSI reset literals
package bridge_cfg_pkg;
   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [7:0] OFS_IO_TOP   = 8'h30;
   localparam logic [7:0] OFS_CAP_HEAD = 8'h34;
   localparam logic [7:0] OFS_IRQ_BRG  = 8'h3c;
   localparam logic [7:0] OFS_PM_CAP   = 8'h40;
   // ==========================================================
   // Reset values
   localparam logic [15:0] IO_TOP_RST   = 16'h0000;
   localparam logic [7:0]  CAP_HEAD_VAL = 8'h40;
   localparam logic [7:0]  IRQ_LINE_RST = 8'h00;
   localparam logic [7:0]  IRQ_PIN_RST  = 8'h00;
   localparam logic [7:0]  PM_CAP_ID    = 8'h01;
   localparam logic [7:0]  PM_NEXT_UP   = 8'h5c;
   localparam logic [7:0]  PM_NEXT_DN   = 8'h4c;
   localparam logic [2:0]  PM_REV       = 3'h3;
   localparam logic [2:0]  AUX_CUR_RST  = 3'h7;
   localparam logic [4:0]  WAKE_SUP_RST = 5'h1f;
   // ==========================================================
   // Bridge control bit positions within the 3Ch dword
   localparam int BC_POISON = 16;
   localparam int BC_ERRFWD = 17;
   localparam int BC_ISA    = 18;
   localparam int BC_VGA    = 19;
   localparam int BC_VGA16  = 20;
   localparam int BC_SBR    = 22;
   // ==========================================================
   // Power capability field positions
   localparam int PM_DSI    = 21;
   localparam int PM_AUX_LO = 22;
   localparam int PM_D1     = 25;
   localparam int PM_D2     = 26;
   localparam int PM_WAKE_LO = 27;
   // ==========================================================
   // VGA windows
   localparam logic [31:0] VGA_MEM_LO = 32'h000a_0000;
   localparam logic [31:0] VGA_MEM_HI = 32'h000b_ffff;
   localparam logic [9:0]  VGA_IO_A_LO = 10'h3b0;
   localparam logic [9:0]  VGA_IO_A_HI = 10'h3bb;
   localparam logic [9:0]  VGA_IO_B_LO = 10'h3c0;
   localparam logic [9:0]  VGA_IO_B_HI = 10'h3df;
endpackage

// ==== hw/bridge_cfg_tail.sv ====
// Purpose: Bridge header tail registers: I/O top, capability head,
//          interrupt bytes, bridge control and power capability
// Assumes: One-cycle config read/write strobes, byte enables per dword
// Notes:   Loader port rewrites only the loadable read-only defaults
//
// Overview of operation
// - Writable upper I/O top, reset zero
// - Capability head reads 40h
// - Interrupt pin byte, loadable on downstream ports
// - Bit 16 enables poisoned TLP reporting
// - Bit 17 gates error message forwarding
// - Bit 18 sends ISA alias range upstream
// - Bit 19 forwards VGA memory and I/O
// - VGA I/O low ten bits ranges
// - Bit 20 selects 10 or 16-bit compare
// - Bit 22 holds hot reset, port reset
// - Upstream bit 22 resets all downstream ports
// - Legacy bits read zero, top reserved
// - Power capability identifier reads 01h
// - Next pointer 5Ch upstream, 4Ch downstream
// - Revision 011b, wake clock bit zero
// - Device init bit defaults to zero
// - Aux current field defaults to 111b
// - D1 and D2 support default one
// - Wake support field defaults 11111b
// - Loader overwrites read-only power defaults
`timescale 1ns/10ps
`default_nettype none
module bridge_cfg_tail
   import bridge_cfg_pkg::*;
#(
   parameter bit IS_UPSTREAM = 1'b0,  // Port role
   parameter int NUM_RST     = 1      // Port reset outputs
) (
   // Clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        srst_i,
   // Configuration requests
   input  wire logic        cfg_rd_i,
   input  wire logic        cfg_wr_i,
   input  wire logic [7:0]  cfg_addr_i,
   input  wire logic [3:0]  cfg_be_i,
   input  wire logic [31:0] cfg_wdata_i,
   output logic [31:0]      cfg_rdata_o,
   output logic             cfg_ack_o,
   // Default loader (SMBus or EEPROM)
   input  wire logic        load_wr_i,
   input  wire logic [7:0]  load_addr_i,
   input  wire logic [3:0]  load_be_i,
   input  wire logic [31:0] load_wdata_i,
   // Secondary side events
   input  wire logic        poison_seen_i,
   input  wire logic [2:0]  err_msg_i,
   output logic             poison_report_o,
   output logic [2:0]       err_fwd_o,
   // Address decode
   input  wire logic [31:0] io_addr_i,
   input  wire logic        io_in_window_i,
   input  wire logic [31:0] mem_addr_i,
   output logic             io_fwd_up_o,
   output logic             io_fwd_down_o,
   output logic             vga_io_hit_o,
   output logic             vga_mem_hit_o,
   // Window and reset outputs
   output logic [15:0]      io_top_upper_o,
   output logic             hot_reset_o,
   output logic [NUM_RST-1:0] port_rst_n_o
);
   // ==========================================================
   // Elaboration checks
   generate
      if (NUM_RST < 1 || (!IS_UPSTREAM && NUM_RST != 1)) begin : g_bad
         $error("NUM_RST must be 1 on a downstream port");
      end
   endgenerate

   // ==========================================================
   // Byte-enable merge used by both write ports
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // ==========================================================
   // Storage
   logic [15:0] io_top_reg;      // I/O top bits 31:16
   logic [15:0] io_top_next;
   logic [7:0]  irq_line_reg;    // Interrupt line, software only
   logic [7:0]  irq_line_next;
   logic [7:0]  irq_pin_reg;     // Interrupt pin, loadable
   logic [7:0]  irq_pin_next;
   logic [5:0]  bctl_reg;        // Stored bridge control bits
   logic [5:0]  bctl_next;
   logic [10:0] pm_ld_reg;       // Power capability bits 31:21
   logic [10:0] pm_ld_next;
   logic [31:0] rdata_reg;       // Read data
   logic        ack_reg;         // Request answer

   // ==========================================================
   // Address decode
   wire logic hit_io  = (cfg_addr_i[7:2] == OFS_IO_TOP[7:2]);
   wire logic hit_cap = (cfg_addr_i[7:2] == OFS_CAP_HEAD[7:2]);
   wire logic hit_ib  = (cfg_addr_i[7:2] == OFS_IRQ_BRG[7:2]);
   wire logic hit_pm  = (cfg_addr_i[7:2] == OFS_PM_CAP[7:2]);
   wire logic ld_ib   = load_wr_i & (load_addr_i[7:2] == OFS_IRQ_BRG[7:2]);
   wire logic ld_pm   = load_wr_i & (load_addr_i[7:2] == OFS_PM_CAP[7:2]);

   // ==========================================================
   // Dword images as read back
   wire logic [31:0] io_word = {io_top_reg, 16'h0000};
   wire logic [31:0] cap_word = {24'h000000, CAP_HEAD_VAL};
   wire logic [31:0] ib_word;                                 // 3Ch
   assign ib_word = {4'h0,
                     5'h00, bctl_reg[5], 1'b0,
                     bctl_reg[4:0],
                     irq_pin_reg, irq_line_reg};
   wire logic [7:0] pm_next = IS_UPSTREAM ? PM_NEXT_UP : PM_NEXT_DN;
   wire logic [31:0] pm_word = {pm_ld_reg, 1'b0, 1'b0, PM_REV,
                                pm_next, PM_CAP_ID};

   // ==========================================================
   // Read multiplexer, unmapped dwords read zero
   wire logic [31:0] rd_mux = hit_io  ? io_word  :
                              hit_cap ? cap_word :
                              hit_ib  ? ib_word  :
                              hit_pm  ? pm_word  : 32'h0000_0000;

   // ==========================================================
   // Configuration writes to writable fields
   wire logic [31:0] io_merged = merge(io_word, cfg_wdata_i, cfg_be_i);
   wire logic [31:0] ib_merged = merge(ib_word, cfg_wdata_i, cfg_be_i);
   wire logic wr_io = cfg_wr_i & hit_io;
   wire logic wr_ib = cfg_wr_i & hit_ib;
   assign io_top_next   = wr_io ? io_merged[31:16] : io_top_reg;
   assign irq_line_next = wr_ib ? ib_merged[7:0] : irq_line_reg;
   assign bctl_next     = wr_ib ? {ib_merged[BC_SBR],
                                   ib_merged[BC_VGA16:BC_POISON]}
                                : bctl_reg;

   // ==========================================================
   // Loader writes to loadable read-only defaults
   // Upstream pin byte stays fixed: only downstream ports take a pin load
   wire logic [31:0] ld_ib_m = merge(ib_word, load_wdata_i, load_be_i);
   wire logic [31:0] ld_pm_m = merge(pm_word, load_wdata_i, load_be_i);
   assign irq_pin_next = (ld_ib && !IS_UPSTREAM) ? ld_ib_m[15:8]
                                                 : irq_pin_reg;
   assign pm_ld_next   = ld_pm ? ld_pm_m[31:PM_DSI] : pm_ld_reg;

   // ==========================================================
   // Register update
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         io_top_reg   <= IO_TOP_RST;
         irq_line_reg <= IRQ_LINE_RST;
         irq_pin_reg  <= IRQ_PIN_RST;
         bctl_reg     <= 6'h00;
         pm_ld_reg    <= {WAKE_SUP_RST, 1'b1, 1'b1, AUX_CUR_RST, 1'b0};
      end else begin
         io_top_reg   <= io_top_next;
         irq_line_reg <= irq_line_next;
         irq_pin_reg  <= irq_pin_next;
         bctl_reg     <= bctl_next;
         pm_ld_reg    <= pm_ld_next;
      end
   end

   // ==========================================================
   // Answer path: data and ack one cycle after the request
   // Read data falls back to zero in cycles with no read taken
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         rdata_reg <= 32'h0000_0000;
         ack_reg   <= 1'b0;
      end else begin
         rdata_reg <= cfg_rd_i ? rd_mux : 32'h0000_0000;
         ack_reg   <= cfg_rd_i | cfg_wr_i;
      end
   end
   assign cfg_rdata_o = rdata_reg;
   assign cfg_ack_o   = ack_reg;

   // ==========================================================
   // Secondary event gating
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         poison_report_o <= 1'b0;
         err_fwd_o       <= 3'h0;
      end else begin
         poison_report_o <= poison_seen_i & bctl_reg[0];
         err_fwd_o       <= err_msg_i & {3{bctl_reg[1]}};
      end
   end

   // ==========================================================
   // Hot reset and port reset outputs
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         hot_reset_o  <= 1'b0;
         port_rst_n_o <= '1;
      end else begin
         hot_reset_o  <= bctl_reg[5];
         port_rst_n_o <= {NUM_RST{~bctl_reg[5]}};
      end
   end
   assign io_top_upper_o = io_top_reg;

   // ==========================================================
   // ISA and VGA decode
   legacy_decode u_decode (
      .sys_clk_i      (sys_clk_i),
      .srst_i         (srst_i),
      .isa_en_i       (bctl_reg[2]),
      .vga_en_i       (bctl_reg[3]),
      .vga16_i        (bctl_reg[4]),
      .io_addr_i      (io_addr_i),
      .io_in_window_i (io_in_window_i),
      .mem_addr_i     (mem_addr_i),
      .io_fwd_up_o    (io_fwd_up_o),
      .io_fwd_down_o  (io_fwd_down_o),
      .vga_io_hit_o   (vga_io_hit_o),
      .vga_mem_hit_o  (vga_mem_hit_o)
   );

   // ==========================================================
   // Assertions
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);

   // I/O top written through both upper byte lanes
   a_io_top_write: assert property (
      (cfg_wr_i && hit_io && cfg_be_i[3:2] == 2'h3)
      |=> io_top_upper_o == $past(cfg_wdata_i[31:16]))
      else $error("I/O top not written");

   // Capability head constant
   a_cap_head: assert property (
      (cfg_rd_i && hit_cap) |=> (cfg_ack_o && cfg_rdata_o == 32'h0000_0040))
      else $error("Capability head wrong");

   // Pin byte fixed on the upstream port
   a_pin_fixed: assert property (
      IS_UPSTREAM |-> irq_pin_reg == IRQ_PIN_RST)
      else $error("Upstream pin byte changed");

   // Poison reporting follows enable
   a_poison_gate: assert property (
      poison_seen_i |=> (poison_report_o == $past(bctl_reg[0])))
      else $error("Poison gating wrong");

   // Error forwarding blocked while disabled
   a_err_block: assert property (
      (!bctl_reg[1] ##1 1'b1) |-> err_fwd_o == 3'h0)
      else $error("Error forwarded while off");

   // ISA alias forwarded upstream, never both ways
   a_isa_route: assert property (
      (bctl_reg[2] && io_in_window_i && io_addr_i[31:16] == 16'h0000
       && io_addr_i[9:8] != 2'h0) |=> (io_fwd_up_o && !io_fwd_down_o))
      else $error("ISA routing wrong");

   // VGA memory window decode
   a_vga_mem: assert property (
      (bctl_reg[3] && mem_addr_i == 32'h000b_ffff) |=> vga_mem_hit_o)
      else $error("VGA memory miss");

   // VGA I/O outside ranges never hits
   a_vga_io_gap: assert property (
      (io_addr_i[9:0] == 10'h3bc) |=> !vga_io_hit_o)
      else $error("VGA I/O false hit");

   // Sixteen-bit compare rejects aliases
   a_vga_16bit: assert property (
      (bctl_reg[4] && io_addr_i[15:10] != 6'h00) |=> !vga_io_hit_o)
      else $error("VGA alias accepted");

   // Port reset tracks the stored bit
   a_port_reset: assert property (
      $rose(bctl_reg[5]) |=> (hot_reset_o && port_rst_n_o[0] == 1'b0))
      else $error("Port reset not asserted");

   // All port resets move together
   a_rst_together: assert property (
      port_rst_n_o == '0 || port_rst_n_o == '1)
      else $error("Port resets diverge");

   // Legacy and reserved bridge bits read zero
   a_legacy_zero: assert property (
      $past(cfg_rd_i && hit_ib) |-> cfg_rdata_o[31:23] == 9'h000
          && cfg_rdata_o[21] == 1'b0)
      else $error("Legacy bit set");

   // Identifier, pointer and revision fixed
   a_pm_header: assert property (
      (cfg_rd_i && hit_pm) |=> cfg_rdata_o[19:0] ==
          {1'b0, PM_REV, IS_UPSTREAM ? 8'h5c : 8'h4c, 8'h01})
      else $error("Power header wrong");

   // Loader-only fields ignore configuration writes
   a_pm_cfg_ro: assert property (
      (cfg_wr_i && hit_pm && !ld_pm) |=> $stable(pm_ld_reg))
      else $error("Config write changed power field");

   // Reset defaults of loadable power fields
   a_pm_default: assert property (
      $fell(srst_i) |-> pm_ld_reg == 11'h7fe)
      else $error("Power defaults wrong");

   // Interrupt line stores a full write
   a_irq_line: assert property (
      (cfg_wr_i && hit_ib && cfg_be_i[0]) |=> irq_line_reg == $past(cfg_wdata_i[7:0]))
      else $error("Interrupt line not written");

   // Unmapped reads return zero
   a_unmapped: assert property (
      (cfg_rd_i && !(hit_io || hit_cap || hit_ib || hit_pm))
      |=> cfg_rdata_o == 32'h0000_0000)
      else $error("Unmapped read nonzero");

   // Pin byte takes a downstream loader write
   a_pin_load: assert property (
      (ld_ib && !IS_UPSTREAM && load_be_i[1]) |=> irq_pin_reg == $past(load_wdata_i[15:8]))
      else $error("Pin byte not loaded");

   // Resets held for as long as the bit stays set
   a_reset_hold: assert property (
      bctl_reg[5] |=> (hot_reset_o && port_rst_n_o == '0))
      else $error("Port reset released early");

   // VGA decode silent while disabled
   a_vga_off: assert property (
      !bctl_reg[3] |=> !(vga_io_hit_o || vga_mem_hit_o))
      else $error("VGA hit while disabled");
endmodule // bridge_cfg_tail
`default_nettype wire

// ==== hw/legacy_decode.sv ====
// Purpose: ISA and VGA address decode for the bridge
// Assumes: Addresses and window hit sampled on sys_clk_i
// Notes:   All results appear one cycle after the inputs
`timescale 1ns/10ps
`default_nettype none
module legacy_decode
   import bridge_cfg_pkg::*;
(
   // Clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        srst_i,
   // Controls
   input  wire logic        isa_en_i,
   input  wire logic        vga_en_i,
   input  wire logic        vga16_i,
   // Addresses
   input  wire logic [31:0] io_addr_i,
   input  wire logic        io_in_window_i,
   input  wire logic [31:0] mem_addr_i,
   // Results
   output logic             io_fwd_up_o,
   output logic             io_fwd_down_o,
   output logic             vga_io_hit_o,
   output logic             vga_mem_hit_o
);
   // ==========================================================
   // Combinational decode
   wire logic [9:0] io_low10 = io_addr_i[9:0];   // Low ten bits
   wire logic first64k = (io_addr_i[31:16] == 16'h0000); // Under 64KB
   wire logic top768 = (io_addr_i[9:8] != 2'h0);  // Top 768 of 1KB
   wire logic isa_up = isa_en_i & io_in_window_i & first64k & top768;
   wire logic low_ok = ((io_low10 >= VGA_IO_A_LO) && (io_low10 <= VGA_IO_A_HI))
                    || ((io_low10 >= VGA_IO_B_LO) && (io_low10 <= VGA_IO_B_HI));
   wire logic hi_ok = ~vga16_i | (io_addr_i[15:10] == 6'h00);
   wire logic vio = vga_en_i & first64k & low_ok & hi_ok;
   wire logic vmem = vga_en_i & (mem_addr_i >= VGA_MEM_LO)
                   & (mem_addr_i <= VGA_MEM_HI);
   // ==========================================================
   // Registered results
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         io_fwd_up_o   <= 1'b0;
         io_fwd_down_o <= 1'b0;
         vga_io_hit_o  <= 1'b0;
         vga_mem_hit_o <= 1'b0;
      end else begin
         io_fwd_up_o   <= isa_up;
         io_fwd_down_o <= io_in_window_i & ~isa_up;
         vga_io_hit_o  <= vio;
         vga_mem_hit_o <= vmem;
      end
   end
endmodule // legacy_decode
`default_nettype wire
